/* design/bsr_avg_decode.sv */
// bsr_avg_decode: turns the averaging codes into sample counts
// assumes codes come straight from averaging_config
`timescale 1ns/10ps
module bsr_avg_decode
   import bsr_pkg::*;
(
   // codes
   input  wire logic [3:0] p_code,
   input  wire logic [2:0] t_code,
   // counts
   output logic      [9:0] p_count,
   output logic      [7:0] t_count
);
   function automatic logic [9:0] p_decode(input logic [3:0] c);
      logic [9:0] v;
      v = 10'h000;
      if (c <= 4'h8)
         v = 10'(10'h001 << c);
      else if (c == AVG_P_384_CODE)
         v = AVG_P_384;
      else
         v = AVG_P_512;                           // codes above 1010 saturate
      return v;
   endfunction : p_decode

   assign p_count = p_decode(p_code);
   assign t_count = 8'(8'h01 << t_code);
endmodule : bsr_avg_decode

/* design/bsr_pkg.sv */
// bsr_pkg: constants and carriers for the barometric sensor register map
// assumes a byte-wide register access port driven by the serial front end
package bsr_pkg;
   localparam int unsigned ADDR_W = 7;
   localparam int unsigned DATA_W = 8;

   localparam logic [6:0] ADDR_REF_LOW    = 7'h08;
   localparam logic [6:0] ADDR_REF_MID    = 7'h09;
   localparam logic [6:0] ADDR_REF_HIGH   = 7'h0A;
   localparam logic [6:0] ADDR_DEV_ID     = 7'h0F;
   localparam logic [6:0] ADDR_AVG_CFG    = 7'h10;
   localparam logic [6:0] ADDR_CTRL_FIRST = 7'h20;
   localparam logic [6:0] ADDR_CTRL_SEC   = 7'h21;
   localparam logic [6:0] ADDR_INT_PIN    = 7'h22;
   localparam logic [6:0] ADDR_INT_CFG    = 7'h23;
   localparam logic [6:0] ADDR_INT_SRC    = 7'h24;
   localparam logic [6:0] ADDR_THS_LOW    = 7'h25;
   localparam logic [6:0] ADDR_THS_HIGH   = 7'h26;
   localparam logic [6:0] ADDR_STATUS     = 7'h27;
   localparam logic [6:0] ADDR_P_OUT_LOW  = 7'h28;
   localparam logic [6:0] ADDR_P_OUT_MID  = 7'h29;
   localparam logic [6:0] ADDR_P_OUT_HIGH = 7'h2A;
   localparam logic [6:0] ADDR_T_OUT_LOW  = 7'h2B;
   localparam logic [6:0] ADDR_T_OUT_HIGH = 7'h2C;
   localparam logic [6:0] ADDR_AMPLIFIER_CONTROL   = 7'h30;

   localparam logic [7:0] RST_REF      = 8'h00;
   localparam logic [7:0] RST_AVG_CFG  = 8'h7A;
   localparam logic [7:0] RST_CTRL     = 8'h00;
   localparam logic [7:0] RST_AMPLIFIER_CONTROL = 8'h00;

   // field positions in averaging_config
   localparam int unsigned AVG_P_LSB = 0;
   localparam int unsigned AVG_T_LSB = 4;
   localparam logic [3:0]  AVG_P_MAX = 4'hA;

   // averaged sample counts for the two odd pressure codes
   localparam logic [9:0]  AVG_P_384 = 10'h180;
   localparam logic [9:0]  AVG_P_512 = 10'h200;
   localparam logic [3:0]  AVG_P_384_CODE = 4'h9;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [6:0] addr;
      logic [7:0] wdata;
   } bsr_acc_s;

   typedef struct packed {
      logic        valid;
      logic [23:0] pressure;
      logic [15:0] temperature;
   } bsr_sample_s;
endpackage : bsr_pkg

/* design/bsr_ref_adder.sv */
// bsr_ref_adder: adds the signed reference to the raw pressure
// assumes raw pressure is a 24-bit two's complement value
`timescale 1ns/10ps
module bsr_ref_adder
   import bsr_pkg::*;
(
   // operands
   input  wire logic [23:0] raw_pressure,
   input  wire logic [23:0] reference,
   // result
   output logic      [23:0] sum_pressure
);
   // wraps modulo 2^24, no saturation is specified
   assign sum_pressure = 24'($signed(raw_pressure) + $signed(reference));
endmodule : bsr_ref_adder

/* design/bsr_regmap.sv */
// bsr_regmap: register bank of the barometric sensor
// assumes a serial front end presents one byte access per cycle,
// with the auto-increment flag and start address of each transfer
`timescale 1ns/10ps
// Notes on behaviour
// - registers are 8 bits wide and addressed by a 7-bit address.
// - the reference pressure lives at 08h, 09h, 0Ah and clears to 00h.
// - the three reference bytes form one signed 24-bit value, 0Ah on top.
// - the signed reference is added to the sensed pressure for output.
// - factory calibration is reloaded on every power-up.
// - averaging_config resets to 7Ah; bit 7 spare, 6:4 temp, 3:0 press.
// - pressure codes 0 to 8 double from 1 to 256, 9 gives 384, 10 gives 512.
// - temperature codes 0 to 7 double from 1 to 128.
// - pressure reads at 28h-2Ah and temperature at 2Bh-2Ch.
// - a set top sub-address bit asks for address auto-increment.
// - with the increment flag the address steps per byte, else it stays.
module bsr_regmap
   import bsr_pkg::*;
#(
   parameter logic [7:0] DEVICE_ID = 8'h5A  // arbitrary identifier value
)
(
   // clock and reset
   input  wire logic        REF_CLK,
   input  wire logic        RST,
   // transfer framing from the serial front end
   input  wire logic        XFER_START,
   input  wire logic [6:0]  XFER_ADDR,
   input  wire logic        XFER_AUTO_INC,
   // byte access within a transfer
   input  wire logic        BYTE_WR,
   input  wire logic        BYTE_RD,
   input  wire logic [7:0]  BYTE_WDATA,
   output logic      [7:0]  BYTE_RDATA,
   output logic      [6:0]  CUR_ADDR,
   // calibration load at power-up
   input  wire logic [7:0]  CAL_AMP_VALUE,
   // samples from the conversion core
   input  wire bsr_sample_s SAMPLE,
   // configuration toward the conversion core
   output logic      [9:0]  PRESS_AVG_COUNT,
   output logic      [7:0]  TEMP_AVG_COUNT,
   output logic      [23:0] REFERENCE_VALUE,
   output logic      [7:0]  CTRL_FIRST,
   output logic      [7:0]  CTRL_SECOND
);
   // the decode and the byte lanes are built for this exact geometry
   if (ADDR_W != 7 || DATA_W != 8)
      $error("register geometry not supported");

   ////////////////////////////////////////////////////////////////////////
   // storage
   logic [7:0]  ref_low_r,  ref_mid_r,  ref_high_r;
   logic [7:0]  avg_cfg_r;
   logic [7:0]  ctrl1_r, ctrl2_r, ctrl3_r, int_cfg_r;
   logic [7:0]  ths_low_r, ths_high_r;
   logic [7:0]  amp_r;
   logic        cal_loaded_r;
   logic [23:0] p_out_r;
   logic [15:0] t_out_r;
   logic        p_new_r, t_new_r;
   logic [6:0]  addr_r, addr_nxt;
   logic [7:0]  rdata_r, rdata_nxt;

   ////////////////////////////////////////////////////////////////////////
   // address sequencing
   wire logic [6:0] acc_addr = XFER_START ? XFER_ADDR : addr_r;
   wire logic       acc     = BYTE_WR | BYTE_RD;
   logic            inc_r;

   always_comb
   begin
      addr_nxt = addr_r;
      if (XFER_START)
         addr_nxt = XFER_ADDR;
      if (acc && (XFER_START ? XFER_AUTO_INC : inc_r))
         addr_nxt = 7'(acc_addr + 7'h01);
   end

   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         addr_r <= 7'h00;
         inc_r  <= 1'b0;
      end
      else
      begin
         addr_r <= addr_nxt;
         if (XFER_START)
            inc_r <= XFER_AUTO_INC;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // write decode; reserved and read-only targets are dropped
   wire logic wr_ref_low  = BYTE_WR && acc_addr == ADDR_REF_LOW;
   wire logic wr_ref_mid  = BYTE_WR && acc_addr == ADDR_REF_MID;
   wire logic wr_ref_high = BYTE_WR && acc_addr == ADDR_REF_HIGH;
   wire logic wr_avg      = BYTE_WR && acc_addr == ADDR_AVG_CFG;
   wire logic wr_ctrl1    = BYTE_WR && acc_addr == ADDR_CTRL_FIRST;
   wire logic wr_ctrl2    = BYTE_WR && acc_addr == ADDR_CTRL_SEC;
   wire logic wr_ctrl3    = BYTE_WR && acc_addr == ADDR_INT_PIN;
   wire logic wr_int_cfg  = BYTE_WR && acc_addr == ADDR_INT_CFG;
   wire logic wr_ths_low  = BYTE_WR && acc_addr == ADDR_THS_LOW;
   wire logic wr_ths_high = BYTE_WR && acc_addr == ADDR_THS_HIGH;
   wire logic wr_amp      = BYTE_WR && acc_addr == ADDR_AMPLIFIER_CONTROL;

   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         ref_low_r  <= RST_REF;
         ref_mid_r  <= RST_REF;
         ref_high_r <= RST_REF;
         avg_cfg_r  <= RST_AVG_CFG;
         ctrl1_r    <= RST_CTRL;
         ctrl2_r    <= RST_CTRL;
         ctrl3_r    <= RST_CTRL;
         int_cfg_r  <= RST_CTRL;
         ths_low_r  <= RST_CTRL;
         ths_high_r <= RST_CTRL;
      end
      else
      begin
         if (wr_ref_low)  ref_low_r  <= BYTE_WDATA;
         if (wr_ref_mid)  ref_mid_r  <= BYTE_WDATA;
         if (wr_ref_high) ref_high_r <= BYTE_WDATA;
         if (wr_avg)      avg_cfg_r  <= BYTE_WDATA;
         if (wr_ctrl1)    ctrl1_r    <= BYTE_WDATA;
         if (wr_ctrl2)    ctrl2_r    <= BYTE_WDATA;
         if (wr_ctrl3)    ctrl3_r    <= BYTE_WDATA;
         if (wr_int_cfg)  int_cfg_r  <= BYTE_WDATA;
         if (wr_ths_low)  ths_low_r  <= BYTE_WDATA;
         if (wr_ths_high) ths_high_r <= BYTE_WDATA;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // calibration: trim value captured on the first cycle after reset,
   // so every power-up restores the factory content
   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         cal_loaded_r <= 1'b0;
         amp_r        <= RST_AMPLIFIER_CONTROL;
      end
      else if (!cal_loaded_r)
      begin
         cal_loaded_r <= 1'b1;
         amp_r        <= CAL_AMP_VALUE;
      end
      else if (wr_amp)
         amp_r <= BYTE_WDATA;
   end

   ////////////////////////////////////////////////////////////////////////
   // output data path
   wire logic [23:0] ref_value = {ref_high_r, ref_mid_r, ref_low_r};
   logic      [23:0] sum_pressure;

   bsr_ref_adder u_adder
   (
      .raw_pressure (SAMPLE.pressure),
      .reference    (ref_value),
      .sum_pressure (sum_pressure)
   );

   bsr_avg_decode u_avg
   (
      .p_code  (avg_cfg_r[AVG_P_LSB +: 4]),
      .t_code  (avg_cfg_r[AVG_T_LSB +: 3]),
      .p_count (PRESS_AVG_COUNT),
      .t_count (TEMP_AVG_COUNT)
   );

   // sample registers ignore host writes entirely
   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         p_out_r <= 24'h000000;
         t_out_r <= 16'h0000;
         p_new_r <= 1'b0;
         t_new_r <= 1'b0;
      end
      else
      begin
         if (SAMPLE.valid)
         begin
            p_out_r <= sum_pressure;
            t_out_r <= SAMPLE.temperature;
         end
         // set wins over the read-clear
         p_new_r <= SAMPLE.valid
                    | (p_new_r & ~(BYTE_RD && acc_addr == ADDR_P_OUT_HIGH));
         t_new_r <= SAMPLE.valid
                    | (t_new_r & ~(BYTE_RD && acc_addr == ADDR_T_OUT_HIGH));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read mux; unmapped and reserved addresses read 00h
   always_comb
   begin
      case (acc_addr)
         ADDR_REF_LOW:    rdata_nxt = ref_low_r;
         ADDR_REF_MID:    rdata_nxt = ref_mid_r;
         ADDR_REF_HIGH:   rdata_nxt = ref_high_r;
         ADDR_DEV_ID:     rdata_nxt = DEVICE_ID;
         ADDR_AVG_CFG:    rdata_nxt = avg_cfg_r;
         ADDR_CTRL_FIRST: rdata_nxt = ctrl1_r;
         ADDR_CTRL_SEC:   rdata_nxt = ctrl2_r;
         ADDR_INT_PIN:    rdata_nxt = ctrl3_r;
         ADDR_INT_CFG:    rdata_nxt = int_cfg_r;
         ADDR_INT_SRC:    rdata_nxt = 8'h00;
         ADDR_THS_LOW:    rdata_nxt = ths_low_r;
         ADDR_THS_HIGH:   rdata_nxt = ths_high_r;
         ADDR_STATUS:     rdata_nxt = {6'h00, p_new_r, t_new_r};
         ADDR_P_OUT_LOW:  rdata_nxt = p_out_r[7:0];
         ADDR_P_OUT_MID:  rdata_nxt = p_out_r[15:8];
         ADDR_P_OUT_HIGH: rdata_nxt = p_out_r[23:16];
         ADDR_T_OUT_LOW:  rdata_nxt = t_out_r[7:0];
         ADDR_T_OUT_HIGH: rdata_nxt = t_out_r[15:8];
         ADDR_AMPLIFIER_CONTROL:   rdata_nxt = amp_r;
         default:         rdata_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge REF_CLK)
   begin
      if (RST)
         rdata_r <= 8'h00;
      else if (BYTE_RD)
         rdata_r <= rdata_nxt;
   end

   assign BYTE_RDATA      = rdata_r;
   assign CUR_ADDR        = addr_r;
   assign REFERENCE_VALUE = ref_value;
   assign CTRL_FIRST      = ctrl1_r;
   assign CTRL_SECOND     = ctrl2_r;
endmodule : bsr_regmap

/* verification/bsr_host.sv */
// bsr_host: byte-level host in place of the serial bus master
// assumes calls start at a falling edge of REF_CLK
`timescale 1ns/10ps
module bsr_host
   import bsr_pkg::*;
(
   // clock
   input  wire logic       REF_CLK,
   // byte access toward the register map
   output logic            XFER_START,
   output logic [6:0]      XFER_ADDR,
   output logic            XFER_AUTO_INC,
   output logic            BYTE_WR,
   output logic            BYTE_RD,
   output logic [7:0]      BYTE_WDATA,
   input  wire logic [7:0] BYTE_RDATA
);
   function automatic logic resv(input logic [6:0] a);
      return a <= 7'h07 || a inside {[7'h0D:7'h0E], [7'h11:7'h1F],
                                     [7'h2D:7'h2F]};
   endfunction : resv
   ////////////////////////////////////////
   // held over one rising edge; next call or idle() releases it
   task automatic acc(input logic st, input logic [6:0] a, input logic inc,
      input logic wr, input logic [7:0] wd, output logic [7:0] rd);
      XFER_START = st;
      XFER_ADDR = st ? a : ~a;
      XFER_AUTO_INC = inc;
      BYTE_WR = wr && !resv(a) && a != ADDR_AMPLIFIER_CONTROL;
      BYTE_RD = !wr;
      BYTE_WDATA = wr ? wd : ~wd;
      @(negedge REF_CLK);
      rd = BYTE_RDATA;
   endtask : acc
   // released lines show junk, not the last value
   task automatic idle;
      XFER_START = 1'b0;
      BYTE_WR = 1'b0;
      BYTE_RD = 1'b0;
      XFER_ADDR = ~XFER_ADDR;
      BYTE_WDATA = ~BYTE_WDATA;
   endtask : idle
   initial
   begin
      XFER_ADDR = 7'h00;
      BYTE_WDATA = 8'h00;
      XFER_AUTO_INC = 1'b0;
      idle();
   end
endmodule : bsr_host

/* verification/bsr_regmap_asserts.sv */
// bsr_regmap_asserts: port checks of the register map
// assumes binding onto bsr_regmap, one clock REF_CLK
`timescale 1ns/10ps
module bsr_regmap_asserts
   import bsr_pkg::*;
#(
   parameter logic [7:0] DEVICE_ID = 8'h5A  // arbitrary identifier value
)
(
   // clock and reset
   input wire logic        REF_CLK,
   input wire logic        RST,
   // byte access
   input wire logic        XFER_START,
   input wire logic [6:0]  XFER_ADDR,
   input wire logic        XFER_AUTO_INC,
   input wire logic        BYTE_WR,
   input wire logic        BYTE_RD,
   input wire logic [7:0]  BYTE_WDATA,
   input wire logic [7:0]  BYTE_RDATA,
   input wire logic [6:0]  CUR_ADDR,
   // configuration
   input wire logic [9:0]  PRESS_AVG_COUNT,
   input wire logic [7:0]  TEMP_AVG_COUNT,
   input wire logic [23:0] REFERENCE_VALUE
);
   wire       st = XFER_START && (BYTE_WR || BYTE_RD);
   wire [3:0] pc = BYTE_RDATA[3:0];
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RST);
   ////////////////////////////////////////
   a_reset_vals: assert property (
      $fell(RST) |-> REFERENCE_VALUE == 24'h000000 && CUR_ADDR == 7'h00
      && PRESS_AVG_COUNT == 10'h200 && TEMP_AVG_COUNT == 8'h80)
      else $error("reset value wrong");
   a_inc_step: assert property (
      st && XFER_AUTO_INC |=> CUR_ADDR == 7'($past(XFER_ADDR) + 7'h01))
      else $error("address did not step");
   a_no_inc: assert property (
      st && !XFER_AUTO_INC |=> CUR_ADDR == $past(XFER_ADDR))
      else $error("address moved");
   a_ref_high: assert property (
      st && BYTE_WR && XFER_ADDR == ADDR_REF_HIGH
      |=> REFERENCE_VALUE[23:16] == $past(BYTE_WDATA))
      else $error("reference top byte wrong");
   a_id_read: assert property (
      st && BYTE_RD && XFER_ADDR == ADDR_DEV_ID |=> BYTE_RDATA == DEVICE_ID)
      else $error("identifier wrong");
   a_resv_read: assert property (
      st && BYTE_RD && XFER_ADDR inside {[7'h00:7'h07], [7'h11:7'h1F]}
      |=> BYTE_RDATA == 8'h00)
      else $error("unmapped read not zero");
   a_temp_count: assert property (
      st && BYTE_RD && XFER_ADDR == ADDR_AVG_CFG
      |=> TEMP_AVG_COUNT == 8'(8'h01 << BYTE_RDATA[6:4]))
      else $error("temperature count wrong");
   a_press_count: assert property (
      st && BYTE_RD && XFER_ADDR == ADDR_AVG_CFG |=> PRESS_AVG_COUNT ==
      (pc <= 4'h8 ? 10'(10'h001 << pc) : (pc == 4'h9 ? 10'h180 : 10'h200)))
      else $error("pressure count wrong");
   a_rd_hold: assert property (
      !BYTE_RD |=> $stable(BYTE_RDATA))
      else $error("read data moved");
endmodule : bsr_regmap_asserts
bind bsr_regmap bsr_regmap_asserts #(.DEVICE_ID(DEVICE_ID)) u_chk (
   .REF_CLK, .RST, .XFER_START, .XFER_ADDR, .XFER_AUTO_INC, .BYTE_WR,
   .BYTE_RD, .BYTE_WDATA, .BYTE_RDATA, .CUR_ADDR, .PRESS_AVG_COUNT,
   .TEMP_AVG_COUNT, .REFERENCE_VALUE);

/* verification/bsr_regmap_tb.sv */
// bsr_regmap_tb: self-checking bench for the register map
// assumes bsr_host drives the byte port, bench drives the rest
`timescale 1ns/10ps
module bsr_regmap_tb
   import bsr_pkg::*;
;
   typedef struct packed {logic wr; logic [6:0] a; logic [7:0] d;} bsr_row_s;
   localparam logic [7:0]  ID  = 8'h3C;  // arbitrary identifier value
   localparam logic [23:0] REF = 24'hF23456;
   localparam bsr_row_s ROWS [13] = '{'{0, 7'h08, 8'h00}, '{0, 7'h09, 8'h00},
      '{0, 7'h0A, 8'h00}, '{0, 7'h10, 8'h7A}, '{0, 7'h20, 8'h00},
      '{0, 7'h0F, ID}, '{0, 7'h05, 8'h00}, '{1, 7'h0F, 8'hFF},
      '{0, 7'h0F, ID}, '{1, 7'h28, 8'h77}, '{0, 7'h28, 8'h00},
      '{1, 7'h20, 8'hA5}, '{0, 7'h20, 8'hA5}};
   logic        REF_CLK, RST, XFER_START, XFER_AUTO_INC, BYTE_WR, BYTE_RD;
   logic [6:0]  XFER_ADDR, CUR_ADDR;
   logic [7:0]  BYTE_WDATA, BYTE_RDATA, CAL_AMP_VALUE, CTRL_FIRST, rd;
   logic [7:0]  CTRL_SECOND, TEMP_AVG_COUNT;
   logic [9:0]  PRESS_AVG_COUNT;
   logic [23:0] REFERENCE_VALUE;
   logic [39:0] outv;
   bsr_sample_s SAMPLE;
   int          errors, comparisons, cyc;
   bsr_regmap #(.DEVICE_ID(ID)) dut (.REF_CLK, .RST, .XFER_START, .XFER_ADDR,
      .XFER_AUTO_INC, .BYTE_WR, .BYTE_RD, .BYTE_WDATA, .BYTE_RDATA, .CUR_ADDR,
      .CAL_AMP_VALUE, .SAMPLE, .PRESS_AVG_COUNT, .TEMP_AVG_COUNT,
      .REFERENCE_VALUE, .CTRL_FIRST, .CTRL_SECOND);
   bsr_host host (.REF_CLK, .XFER_START, .XFER_ADDR, .XFER_AUTO_INC,
      .BYTE_WR, .BYTE_RD, .BYTE_WDATA, .BYTE_RDATA);
   ////////////////////////////////////////
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic test_done;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : test_done
   // second edge after release is the first legal request
   task automatic reset;
      RST = 1'b1;
      repeat (4) @(negedge REF_CLK);
      RST = 1'b0;
      repeat (2) @(negedge REF_CLK);
   endtask : reset
   initial
   begin
      REF_CLK = 1'b0;
      forever #10 REF_CLK = ~REF_CLK;
   end
   always @(posedge REF_CLK)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         errors++;
         test_done();
      end
   end
   initial
   begin
      RST = 1'b1;
      CAL_AMP_VALUE = 8'h9C;
      SAMPLE = '0;
      reset();
      foreach (ROWS[i])
      begin
         host.acc(1'b1, ROWS[i].a, 1'b0, ROWS[i].wr, ROWS[i].d, rd);
         if (!ROWS[i].wr) check(rd, ROWS[i].d);
      end
      host.acc(1'b1, ADDR_AMPLIFIER_CONTROL, 1'b0, 1'b0, 8'h00, rd);
      check(rd, 8'h9C);
      // codes stay off 7Ah while the output rate is one shot
      for (int i = 0; i <= 10; i++)
      begin
         host.acc(1'b1, ADDR_AVG_CFG, 1'b0, 1'b1, {1'b0, 3'(i), 4'(i)}, rd);
         check(PRESS_AVG_COUNT, i < 9 ? 24'(1 << i) : 24'(i == 9 ? 384 : 512));
         check(TEMP_AVG_COUNT, 24'(1 << (i % 8)));
      end
      host.acc(1'b1, ADDR_AVG_CFG, 1'b0, 1'b0, 8'h00, rd);
      check(rd, 8'h2A);
      for (int i = 0; i < 3; i++)
         host.acc(i == 0, 7'(8 + i), 1'b1, 1'b1, REF[8*i +: 8], rd);
      host.acc(1'b1, ADDR_CTRL_FIRST, 1'b0, 1'b1, 8'h11, rd);
      host.acc(1'b0, ADDR_CTRL_FIRST, 1'b0, 1'b1, 8'h22, rd);
      host.idle();
      check(REFERENCE_VALUE, REF);
      check(CTRL_FIRST, 8'h22);
      check(CTRL_SECOND, 8'h00);
      SAMPLE = '{1'b1, 24'h0F0000, 16'hBEEF};
      @(negedge REF_CLK);
      SAMPLE.valid = 1'b0;
      outv = {16'hBEEF, 24'(24'h0F0000 + REF)};
      host.acc(1'b1, ADDR_STATUS, 1'b0, 1'b0, 8'h00, rd);
      check(rd, 8'h03);
      for (int i = 0; i < 5; i++)
      begin
         host.acc(i == 0, 7'(8'h28 + i), 1'b1, 1'b0, 8'h00, rd);
         check(rd, outv[8*i +: 8]);
      end
      host.acc(1'b1, ADDR_STATUS, 1'b0, 1'b0, 8'h00, rd);
      check(rd, 8'h00);
      host.acc(1'b1, 7'h7F, 1'b1, 1'b0, 8'h00, rd);
      host.idle();
      check(CUR_ADDR, 7'h00);
      CAL_AMP_VALUE = 8'h3E;
      reset();
      host.acc(1'b1, ADDR_AMPLIFIER_CONTROL, 1'b0, 1'b0, 8'h00, rd);
      check(rd, 8'h3E);
      host.acc(1'b1, ADDR_REF_HIGH, 1'b0, 1'b0, 8'h00, rd);
      check(rd, 8'h00);
      host.idle();
      test_done();
   end
endmodule : bsr_regmap_tb
